//--- logic/spc_cfg.svh
// constants for the system privilege, power and clock control block
// assumes a single ref_clk domain and 8-bit configuration registers
`ifndef SPC_CFG_SVH
`define SPC_CFG_SVH
// writable-bit masks of config registers 0..2 (bits that exist)
`define SPC_CFG0_MASK      8'h60
`define SPC_CFG1_MASK      8'h14
`define SPC_CFG2_MASK      8'hdb
// bits locked while nonprivileged
`define SPC_CFG0_PROT      8'h60
`define SPC_CFG1_PROT      8'h14
`define SPC_CFG2_PROT      8'hdb
`define SPC_SER_PROT       8'hf0
`define SPC_TMA_PROT       8'hc0
`define SPC_TMB_PROT       8'hc0
`define SPC_CNV_PROT       8'he0
// bits of register 2
`define SPC_LOCK_BIT       0
`define SPC_NMI_BIT        1
`define SPC_PDSEL_BIT      6
`define SPC_HALT_BIT       7
`define SPC_LP_BITS        8'hc0
// register reset values
`define SPC_REG_RST        8'h00
// register selector codes
`define SPC_SEL_CFG0       3'h0
`define SPC_SEL_CFG1       3'h1
`define SPC_SEL_CFG2       3'h2
`define SPC_SEL_SER        3'h3
`define SPC_SEL_TMA        3'h4
`define SPC_SEL_TMB        3'h5
`define SPC_SEL_CNV        3'h6
// clock divider
`define SPC_DIV4_LAST      2'h3
`endif

//--- logic/spc_pkg.sv
// types for the system privilege, power and clock control block
// assumes spc_cfg.svh is compiled alongside
package spc_pkg;
    typedef enum logic [3:0] {
        SPC_RUN     = 4'b0001,
        SPC_IDLE    = 4'b0010,
        SPC_STANDBY = 4'b0100,
        SPC_HALT    = 4'b1000
    } spc_mode_t;

    // one register write from the cpu
    typedef struct packed {
        logic       en;
        logic [2:0] sel;
        logic [7:0] data;
    } spc_wr_t;

    // wake sources, already synchronised where they come from pins
    typedef struct packed {
        logic irq1;
        logic irq2;
        logic irq3;
        logic timer_a;
        logic rx_low;
    } spc_wake_t;
endpackage : spc_pkg

//--- logic/spc_ctrl.sv
// Function
// - reset leaves the device privileged with all register bits writable
// - writing 1 to priv_lock_bit enters nonprivileged mode
// - nonprivileged mode ignores writes to protected bits of config registers 0..2
// - nonprivileged mode protects priority register bits of serial, timers, converter
// - high voltage on mode pin after reset release enters eeprom override
// - idle instruction enters low power only if powerdown_select set, else idle
// - halt-select bit picks standby (0) or halt (1)
// - standby stops cpu; oscillator, clocks, timer 1, rx start detect run
// - standby exits on reset, any external irq, timer 1 irq, rx low
// - halt stops oscillator and all internal clocks
// - halt exits on reset, external irq or rx low, never timer
// - low power disabled by mask option ignores writes to register 2 bits 6,7
// - low power disabled by mask option makes idle instruction always idle
// - hard watchdog makes irq one nonmaskable during low power modes
// - standby and halt retain cpu, ram, pin and peripheral status
// - watchdog counter clocking inhibited during standby and halt
// - divide-by-4 option gives system clock at quarter resonator rate
// - divide-by-1 option gives system clock equal to resonator rate
// - clock option fixed at manufacture, exactly one present
//
// system control logic: privilege lock, eeprom override, power modes, clock option
// assumes ref_clk is the resonator-derived clock; pin inputs are asynchronous
// cpu state, ram and pin latches live outside; low power only gates their clocks
// mask options are parameters, so one build carries exactly one clock option
`timescale 1ns/10ps
`include "spc_cfg.svh"

module spc_ctrl
    import spc_pkg::*;
#(
    parameter bit LP_DISABLED = 1'b0,   // mask option: low-power modes removed
    parameter bit CLK_DIV4    = 1'b1    // mask option: 1 divide-by-4, 0 divide-by-1
) (
    input  wire logic      ref_clk,           // clock, 100 MHz
    input  wire logic      rst_n,             // synchronous reset, active low
    input  wire spc_wr_t   cpu_wr,            // register write from cpu
    input  wire logic      idle_instr,        // pulse: idle instruction executed
    input  wire logic      hard_wdog,         // hard watchdog mode selected
    input  wire logic      mode_ctrl_pin,     // high-voltage detect on mode pin
    input  wire logic      ext_irq_one,       // external interrupt pin 1 event
    input  wire logic      ext_irq_two,       // external interrupt pin 2 event
    input  wire logic      ext_irq_three,     // external interrupt pin 3 event
    input  wire logic      timer_a_irq,       // timer 1 interrupt, same clock
    input  wire logic      serial_rx_pin,     // serial receive pin level
    output logic [7:0]     sys_cfg_reg0,      // config register 0
    output logic [7:0]     sys_cfg_reg1,      // config register 1
    output logic [7:0]     sys_cfg_reg2,      // config register 2
    output logic [7:0]     serial_priority_reg,     // serial priority bits
    output logic [7:0]     timer_a_priority_reg,    // timer 1 priority bits
    output logic [7:0]     timer_b_priority_reg,    // timer 2 priority bits
    output logic [7:0]     converter_priority_reg,  // converter priority bits
    output logic           priv_mode,         // 1 while privileged
    output logic           eeprom_protect_override, // eeprom_protect_regs writable
    output spc_mode_t      pwr_mode,          // current power mode
    output logic           cpu_clk_en,        // cpu and most peripherals clocked
    output logic           osc_en,            // oscillator and internal clocks run
    output logic           timer_a_clk_en,    // timer 1 and rx start detect clocked
    output logic           wdog_clk_en,       // wdog_counter clock enable
    output logic           irq1_nmi_force,    // irq one forced nonmaskable
    output logic           internal_sys_clock // system clock enable pulse/level
);
    // pin synchronisers, two stages each; only the second stage feeds logic
    logic [4:0] pin_s1_r, pin_s1_nxt;
    logic [4:0] pin_s2_r, pin_s2_nxt;
    always_comb begin
        pin_s1_nxt = {mode_ctrl_pin, ext_irq_one, ext_irq_two, ext_irq_three, serial_rx_pin};
        pin_s2_nxt = pin_s1_r;
    end
    // no reset here: the pipe flushes within the three-edge minimum reset
    always_ff @(posedge ref_clk) begin
        pin_s1_r <= pin_s1_nxt;
        pin_s2_r <= pin_s2_nxt;
    end

    // wake sources gathered in one carrier
    // a pin event needs two edges of sync before it can wake anything
    spc_wake_t wake_src;
    logic      irq_any;
    always_comb begin
        wake_src.irq1    = pin_s2_r[3];
        wake_src.irq2    = pin_s2_r[2];
        wake_src.irq3    = pin_s2_r[1];
        wake_src.timer_a = timer_a_irq;   // same clock, no sync needed
        wake_src.rx_low  = ~pin_s2_r[0];  // start bit or break pulls the line low
        irq_any          = wake_src.irq1 | wake_src.irq2 | wake_src.irq3;
    end

    // masked register update; protected bits hold while locked
    function automatic logic [7:0] upd(input logic [7:0] cur, input logic [7:0] wd,
                                       input logic [7:0] exist, input logic [7:0] prot,
                                       input logic locked);
        logic [7:0] wm;
        wm  = locked ? (exist & ~prot) : exist;
        upd = (cur & ~wm) | (wd & wm);
    endfunction : upd

    // register state
    logic [7:0] cfg0_r, cfg0_nxt, cfg1_r, cfg1_nxt, cfg2_r, cfg2_nxt;
    logic [7:0] ser_r, ser_nxt, tma_r, tma_nxt, tmb_r, tmb_nxt, cnv_r, cnv_nxt;
    logic       lock_r, lock_nxt;
    logic [7:0] wd2;

    always_comb begin
        cfg0_nxt = cfg0_r;
        cfg1_nxt = cfg1_r;
        cfg2_nxt = cfg2_r;
        ser_nxt  = ser_r;
        tma_nxt  = tma_r;
        tmb_nxt  = tmb_r;
        cnv_nxt  = cnv_r;
        wd2      = cpu_wr.data;
        // low-power bits frozen when the mask option removed them
        if (LP_DISABLED)
            wd2 = (cpu_wr.data & ~`SPC_LP_BITS) | (cfg2_r & `SPC_LP_BITS);
        if (cpu_wr.en) begin
            case (cpu_wr.sel)
                `SPC_SEL_CFG0: cfg0_nxt = upd(cfg0_r, cpu_wr.data, `SPC_CFG0_MASK, `SPC_CFG0_PROT, lock_r);
                `SPC_SEL_CFG1: cfg1_nxt = upd(cfg1_r, cpu_wr.data, `SPC_CFG1_MASK, `SPC_CFG1_PROT, lock_r);
                `SPC_SEL_CFG2: cfg2_nxt = upd(cfg2_r, wd2, `SPC_CFG2_MASK, `SPC_CFG2_PROT, lock_r);
                `SPC_SEL_SER:  ser_nxt  = upd(ser_r, cpu_wr.data, 8'hff, `SPC_SER_PROT, lock_r);
                `SPC_SEL_TMA:  tma_nxt  = upd(tma_r, cpu_wr.data, 8'hff, `SPC_TMA_PROT, lock_r);
                `SPC_SEL_TMB:  tmb_nxt  = upd(tmb_r, cpu_wr.data, 8'hff, `SPC_TMB_PROT, lock_r);
                `SPC_SEL_CNV:  cnv_nxt  = upd(cnv_r, cpu_wr.data, 8'hff, `SPC_CNV_PROT, lock_r);
                default: ;
            endcase
        end
        // lock is sticky: a locked write cannot clear it, so only reset unlocks
        lock_nxt = lock_r | cfg2_nxt[`SPC_LOCK_BIT];
    end

    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            cfg0_r <= `SPC_REG_RST;
            cfg1_r <= `SPC_REG_RST;
            cfg2_r <= `SPC_REG_RST;
            ser_r  <= `SPC_REG_RST;
            tma_r  <= `SPC_REG_RST;
            tmb_r  <= `SPC_REG_RST;
            cnv_r  <= `SPC_REG_RST;
            lock_r <= 1'b0;
        end else begin
            cfg0_r <= cfg0_nxt;
            cfg1_r <= cfg1_nxt;
            cfg2_r <= cfg2_nxt;
            ser_r  <= ser_nxt;
            tma_r  <= tma_nxt;
            tmb_r  <= tmb_nxt;
            cnv_r  <= cnv_nxt;
            lock_r <= lock_nxt;
        end
    end

    // eeprom override: entered by high voltage seen after reset release
    logic wpo_r, wpo_nxt;
    always_comb begin
        wpo_nxt = pin_s2_r[4];
    end
    always_ff @(posedge ref_clk) begin
        if (!rst_n)
            wpo_r <= 1'b0;
        else
            wpo_r <= wpo_nxt;
    end

    // power mode sequencer; registers and ram are simply not reset here
    spc_mode_t mode_r, mode_nxt;
    logic      wake_sb, wake_ht;
    always_comb begin
        // idle wakes on the standby sources; halt has no running timer to wake it
        wake_sb  = irq_any | wake_src.timer_a | wake_src.rx_low;
        wake_ht  = irq_any | wake_src.rx_low;                     // timers cannot wake
        mode_nxt = mode_r;
        case (mode_r)
            SPC_RUN: begin
                if (idle_instr) begin
                    if (LP_DISABLED || !cfg2_r[`SPC_PDSEL_BIT])
                        mode_nxt = SPC_IDLE;
                    else if (cfg2_r[`SPC_HALT_BIT])
                        mode_nxt = SPC_HALT;
                    else
                        mode_nxt = SPC_STANDBY;
                end
            end
            SPC_IDLE:    if (wake_sb) mode_nxt = SPC_RUN;
            SPC_STANDBY: if (wake_sb) mode_nxt = SPC_RUN;
            SPC_HALT:    if (wake_ht) mode_nxt = SPC_RUN;
            default:     mode_nxt = SPC_RUN;
        endcase
    end
    always_ff @(posedge ref_clk) begin
        if (!rst_n)
            mode_r <= SPC_RUN;  // reset always exits low power
        else
            mode_r <= mode_nxt;
    end

    // clock option divider, fixed by parameter
    logic [1:0] div_r, div_nxt;
    always_comb begin
        div_nxt = (div_r == `SPC_DIV4_LAST) ? 2'h0 : div_r + 2'h1;
    end
    always_ff @(posedge ref_clk) begin
        if (!rst_n)
            div_r <= 2'h0;
        else
            div_r <= div_nxt;
    end

    // mode classes; mode_awake feeds two clock enables, mode_lowpwr only the irq one nmi force
    function automatic logic mode_awake(input spc_mode_t m);
        mode_awake = (m == SPC_RUN) || (m == SPC_IDLE);
    endfunction : mode_awake

    // low power covers standby and halt, never idle
    function automatic logic mode_lowpwr(input spc_mode_t m);
        mode_lowpwr = (m == SPC_STANDBY) || (m == SPC_HALT);
    endfunction : mode_lowpwr

    // next values of the registered outputs
    logic [7:0] cfg0_out_nxt;
    logic [7:0] cfg1_out_nxt;
    logic [7:0] cfg2_out_nxt;
    logic [7:0] ser_out_nxt;
    logic [7:0] tma_out_nxt;
    logic [7:0] tmb_out_nxt;
    logic [7:0] cnv_out_nxt;
    logic       priv_nxt;
    logic       ovr_nxt;
    spc_mode_t  pwr_nxt;
    logic       cpu_en_nxt;
    logic       osc_en_nxt;
    logic       tma_en_nxt;
    logic       wdog_en_nxt;
    logic       nmi_nxt;
    logic       internal_sys_clock_nxt;

    // outputs load the next state, so they never trail the internal registers
    always_comb begin
        // register images
        cfg0_out_nxt = cfg0_nxt;
        cfg1_out_nxt = cfg1_nxt;
        cfg2_out_nxt = cfg2_nxt;
        ser_out_nxt  = ser_nxt;
        tma_out_nxt  = tma_nxt;
        tmb_out_nxt  = tmb_nxt;
        cnv_out_nxt  = cnv_nxt;
        // privilege, override and mode
        priv_nxt     = ~lock_nxt;
        ovr_nxt      = wpo_nxt;
        pwr_nxt      = mode_nxt;
        // cpu stops in standby and halt; retention is by not resetting
        cpu_en_nxt   = mode_awake(mode_nxt);
        osc_en_nxt   = (mode_nxt != SPC_HALT);
        tma_en_nxt   = (mode_nxt != SPC_HALT);
        wdog_en_nxt  = mode_awake(mode_nxt);
        nmi_nxt      = hard_wdog && mode_lowpwr(mode_nxt);
        // divide-by-4 pulses one cycle in four, divide-by-1 every cycle
        // halt stops the oscillator, so the system clock stops with it
        internal_sys_clock_nxt   = (mode_nxt != SPC_HALT) && (CLK_DIV4 ? (div_nxt == `SPC_DIV4_LAST) : 1'b1);
    end

    // registered outputs; reset leaves the block privileged and running
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            sys_cfg_reg0            <= `SPC_REG_RST;
            sys_cfg_reg1            <= `SPC_REG_RST;
            sys_cfg_reg2            <= `SPC_REG_RST;
            serial_priority_reg     <= `SPC_REG_RST;
            timer_a_priority_reg    <= `SPC_REG_RST;
            timer_b_priority_reg    <= `SPC_REG_RST;
            converter_priority_reg  <= `SPC_REG_RST;
            priv_mode               <= 1'b1;
            eeprom_protect_override <= 1'b0;
            pwr_mode                <= SPC_RUN;
            cpu_clk_en              <= 1'b1;
            osc_en                  <= 1'b1;
            timer_a_clk_en          <= 1'b1;
            wdog_clk_en             <= 1'b1;
            irq1_nmi_force          <= 1'b0;
            internal_sys_clock      <= 1'b0;
        end else begin
            sys_cfg_reg0            <= cfg0_out_nxt;
            sys_cfg_reg1            <= cfg1_out_nxt;
            sys_cfg_reg2            <= cfg2_out_nxt;
            serial_priority_reg     <= ser_out_nxt;
            timer_a_priority_reg    <= tma_out_nxt;
            timer_b_priority_reg    <= tmb_out_nxt;
            converter_priority_reg  <= cnv_out_nxt;
            priv_mode               <= priv_nxt;
            eeprom_protect_override <= ovr_nxt;
            pwr_mode                <= pwr_nxt;
            cpu_clk_en              <= cpu_en_nxt;
            osc_en                  <= osc_en_nxt;
            timer_a_clk_en          <= tma_en_nxt;
            wdog_clk_en             <= wdog_en_nxt;
            irq1_nmi_force          <= nmi_nxt;
            internal_sys_clock      <= internal_sys_clock_nxt;
        end
    end
endmodule : spc_ctrl

//--- test/spc_pins.sv
// pin-side model: mode pin high voltage, irq pins, serial rx line
// assumes the bench calls its tasks just after a ref_clk edge
`timescale 1ns/10ps
module spc_pins (
    input  wire logic  ref_clk,       // clock
    output logic       mode_ctrl_pin, // hv seen
    output logic [2:0] irq_pins,      // irq one..three
    output logic       serial_rx_pin  // rx, pulled up
);
    // rx idles at its pull-up level, irqs low
    initial begin
        mode_ctrl_pin = 1'b0;
        irq_pins      = 3'h0;
        serial_rx_pin = 1'b1;
    end
    // bench only applies this once reset is released
    task automatic hv(input logic lvl);
        mode_ctrl_pin = lvl;
    endtask : hv
    // held four edges so the two-flop sync cannot miss it; two quiet edges
    // after release empty the sync pipe before the caller asks for low power
    task automatic wake(input int src);
        if (src < 3) irq_pins[src] = 1'b1;
        else serial_rx_pin = 1'b0;
        repeat (4) @(posedge ref_clk);
        #1;
        irq_pins      = 3'h0;
        serial_rx_pin = 1'b1;
        repeat (2) @(posedge ref_clk);
        #1;
    endtask : wake
endmodule : spc_pins

//--- test/spc_ctrl_sva.sv
// checker for spc_ctrl: lock, power modes, override, system clock
// assumes it is bound to every spc_ctrl and sees its ports only
`timescale 1ns/10ps
`include "spc_cfg.svh"
module spc_ctrl_sva
    import spc_pkg::*;
#(
    parameter bit LP_DISABLED = 1'b0, // mask option
    parameter bit CLK_DIV4    = 1'b1  // clock option
) (
    input wire logic       ref_clk,                 // clock
    input wire logic       rst_n,                   // reset
    input wire spc_wr_t    cpu_wr,                  // write
    input wire logic       idle_instr,              // idle
    input wire logic       hard_wdog,               // wdog mode
    input wire logic       mode_ctrl_pin,           // hv pin
    input wire logic       ext_irq_one,             // irq 1
    input wire logic       ext_irq_two,             // irq 2
    input wire logic       ext_irq_three,           // irq 3
    input wire logic       timer_a_irq,             // timer
    input wire logic       serial_rx_pin,           // rx
    input wire logic [7:0] sys_cfg_reg2,            // cfg 2
    input wire logic [7:0] serial_priority_reg,     // serial prio
    input wire logic       priv_mode,               // privileged
    input wire logic       eeprom_protect_override, // override
    input wire spc_mode_t  pwr_mode,                // mode
    input wire logic       cpu_clk_en,              // cpu clock
    input wire logic       osc_en,                  // oscillator
    input wire logic       timer_a_clk_en,          // timer clock
    input wire logic       wdog_clk_en,             // wdog clock
    input wire logic       irq1_nmi_force,          // nmi
    input wire logic       internal_sys_clock       // internal_sys_clock
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    logic      wr2;
    logic      wr3;
    spc_mode_t pick;
    // write strobes and the mode an idle would pick now
    always_comb begin
        wr2  = cpu_wr.en && cpu_wr.sel == `SPC_SEL_CFG2;
        wr3  = cpu_wr.en && cpu_wr.sel == `SPC_SEL_SER;
        pick = (LP_DISABLED || !sys_cfg_reg2[6]) ? SPC_IDLE : (sys_cfg_reg2[7] ? SPC_HALT : SPC_STANDBY);
    end
    // three quiet samples: nothing can be left in the sync pipe
    sequence quiet_pins;
        (!ext_irq_one && !ext_irq_two && !ext_irq_three && serial_rx_pin)[*3];
    endsequence
    sequence idle_in_run;
        pwr_mode == SPC_RUN && idle_instr;
    endsequence
    a_lock_enter: assert property (priv_mode && wr2 && cpu_wr.data[0] |=> !priv_mode)
        else $error("lock write left device privileged");
    a_lock_sticky: assert property (!priv_mode |=> !priv_mode)
        else $error("privilege regained without reset");
    a_cfg_frozen: assert property (!priv_mode && wr2 |=> $stable(sys_cfg_reg2))
        else $error("locked cfg2 changed");
    a_prio_frozen: assert property (!priv_mode && wr3 |=>
        serial_priority_reg[7:4] == $past(serial_priority_reg[7:4]))
        else $error("locked serial priority changed");
    a_mode_pick: assert property (idle_in_run |=> pwr_mode == $past(pick))
        else $error("idle entered wrong mode");
    a_halt_stop: assert property (pwr_mode == SPC_HALT |->
        !osc_en && !cpu_clk_en && !wdog_clk_en && !internal_sys_clock)
        else $error("clocks running in halt");
    a_stby_clocks: assert property (pwr_mode == SPC_STANDBY |->
        osc_en && timer_a_clk_en && !cpu_clk_en && !wdog_clk_en)
        else $error("wrong clocks in standby");
    a_halt_deaf: assert property (quiet_pins ##0 pwr_mode == SPC_HALT |=> pwr_mode == SPC_HALT)
        else $error("halt left without pin wake");
    a_stby_timer: assert property (pwr_mode == SPC_STANDBY && timer_a_irq |=> pwr_mode == SPC_RUN)
        else $error("timer did not wake standby");
    a_nmi_hold: assert property ((hard_wdog && pwr_mode == SPC_HALT)[*2] |-> irq1_nmi_force)
        else $error("irq one not forced in halt");
    a_ovr_follow: assert property (mode_ctrl_pin[*4] |-> eeprom_protect_override)
        else $error("override missing after hv");
    a_internal_sys_clock_div: assert property (disable iff (!rst_n || !osc_en)
        CLK_DIV4 && internal_sys_clock |=> !internal_sys_clock[*3] ##1 internal_sys_clock)
        else $error("internal_sys_clock not quarter rate");
endmodule : spc_ctrl_sva
bind spc_ctrl spc_ctrl_sva #(.LP_DISABLED(LP_DISABLED), .CLK_DIV4(CLK_DIV4)) u_sva (
    .ref_clk(ref_clk), .rst_n(rst_n), .cpu_wr(cpu_wr), .idle_instr(idle_instr), .hard_wdog(hard_wdog),
    .mode_ctrl_pin(mode_ctrl_pin), .ext_irq_one(ext_irq_one), .ext_irq_two(ext_irq_two),
    .ext_irq_three(ext_irq_three), .timer_a_irq(timer_a_irq), .serial_rx_pin(serial_rx_pin),
    .sys_cfg_reg2(sys_cfg_reg2), .serial_priority_reg(serial_priority_reg), .priv_mode(priv_mode),
    .eeprom_protect_override(eeprom_protect_override), .pwr_mode(pwr_mode), .cpu_clk_en(cpu_clk_en),
    .osc_en(osc_en), .timer_a_clk_en(timer_a_clk_en), .wdog_clk_en(wdog_clk_en),
    .irq1_nmi_force(irq1_nmi_force), .internal_sys_clock(internal_sys_clock));

//--- test/testbench.sv
// bench for spc_ctrl: default variant plus low-power-off, divide-by-1
// assumes spc_pkg, spc_pins and the checker are compiled first
`timescale 1ns/10ps
`include "spc_cfg.svh"
module testbench
    import spc_pkg::*;
;
    logic       ref_clk, rst_n, idle_instr, hard_wdog, timer_a_irq, mode_ctrl_pin, serial_rx_pin;
    logic       priv, ovr, osc, wd_en, nmi, sclk, sclk2, cpu_en, tma_en;
    logic [2:0] irq_pins;
    logic [7:0] regs [7];
    logic [7:0] reg2b;
    spc_wr_t    cpu_wr;
    spc_mode_t  mode, mode2;
    int         failures, checks_done, n, k;
    logic [7:0] full [7] = '{`SPC_CFG0_MASK, `SPC_CFG1_MASK, `SPC_CFG2_MASK, 8'hff, 8'hff, 8'hff, 8'hff};
    logic [7:0] prot [7] = '{`SPC_CFG0_PROT, `SPC_CFG1_PROT, `SPC_CFG2_PROT, `SPC_SER_PROT,
                             `SPC_TMA_PROT, `SPC_TMB_PROT, `SPC_CNV_PROT};
    // free-running 100 MHz clock
    initial ref_clk = 1'b0;
    always #5 ref_clk = ~ref_clk;
    spc_pins PINS (.ref_clk(ref_clk), .mode_ctrl_pin(mode_ctrl_pin), .irq_pins(irq_pins),
        .serial_rx_pin(serial_rx_pin));
    // default build: low-power modes present, divide-by-4 clock
    spc_ctrl DUT (
        .ref_clk(ref_clk), .rst_n(rst_n), .cpu_wr(cpu_wr), .idle_instr(idle_instr), .hard_wdog(hard_wdog),
        .mode_ctrl_pin(mode_ctrl_pin), .ext_irq_one(irq_pins[0]), .ext_irq_two(irq_pins[1]),
        .ext_irq_three(irq_pins[2]), .timer_a_irq(timer_a_irq), .serial_rx_pin(serial_rx_pin),
        .sys_cfg_reg0(regs[0]), .sys_cfg_reg1(regs[1]), .sys_cfg_reg2(regs[2]), .serial_priority_reg(regs[3]),
        .timer_a_priority_reg(regs[4]), .timer_b_priority_reg(regs[5]), .converter_priority_reg(regs[6]),
        .priv_mode(priv), .eeprom_protect_override(ovr), .pwr_mode(mode), .cpu_clk_en(cpu_en), .osc_en(osc),
        .timer_a_clk_en(tma_en), .wdog_clk_en(wd_en), .irq1_nmi_force(nmi), .internal_sys_clock(sclk));
    // mask variant: low-power modes removed, divide-by-1 clock
    spc_ctrl #(.LP_DISABLED(1'b1), .CLK_DIV4(1'b0)) DUT2 (
        .ref_clk(ref_clk), .rst_n(rst_n), .cpu_wr(cpu_wr), .idle_instr(idle_instr), .hard_wdog(hard_wdog),
        .mode_ctrl_pin(mode_ctrl_pin), .ext_irq_one(irq_pins[0]), .ext_irq_two(irq_pins[1]),
        .ext_irq_three(irq_pins[2]), .timer_a_irq(timer_a_irq), .serial_rx_pin(serial_rx_pin),
        .sys_cfg_reg0(), .sys_cfg_reg1(), .sys_cfg_reg2(reg2b), .serial_priority_reg(),
        .timer_a_priority_reg(), .timer_b_priority_reg(), .converter_priority_reg(),
        .priv_mode(), .eeprom_protect_override(), .pwr_mode(mode2), .cpu_clk_en(), .osc_en(),
        .timer_a_clk_en(), .wdog_clk_en(), .irq1_nmi_force(), .internal_sys_clock(sclk2));
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic close_out();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : close_out
    // inputs always change 1 ns after the edge
    task automatic step();
        @(posedge ref_clk);
        #1;
    endtask : step
    // idle cycle after the strobe keeps en from toggling twice at once
    task automatic wr(input logic [2:0] sel, input logic [7:0] d);
        cpu_wr = '{1'b1, sel, d};
        step();
        cpu_wr.en = 1'b0;
        step();
    endtask : wr
    task automatic idle();
        idle_instr = 1'b1;
        step();
        idle_instr = 1'b0;
        step();
    endtask : idle
    task automatic tick_timer();
        timer_a_irq = 1'b1;
        step();
        timer_a_irq = 1'b0;
    endtask : tick_timer
    // bounded wait for the return to run
    task automatic wait_run();
        repeat (10) if (mode !== SPC_RUN) step();
        chk(mode, SPC_RUN);
        if (mode !== SPC_RUN) close_out();
    endtask : wait_run
    initial begin
        {idle_instr, hard_wdog, timer_a_irq, rst_n} = 4'h0;
        cpu_wr = '0;
        repeat (20) @(posedge ref_clk);
        #1;
        rst_n = 1'b1;
        chk(priv, 1'b1);
        chk(mode, SPC_RUN);
        idle();
        chk(mode, SPC_IDLE);
        tick_timer();
        wr(`SPC_SEL_CFG2, 8'h40);
        idle();
        chk(mode, SPC_STANDBY);
        chk({osc, tma_en, cpu_en, wd_en}, 4'hc);
        chk(mode2, SPC_IDLE);
        chk(reg2b, 8'h00);
        tick_timer();
        chk(mode, SPC_RUN);
        wr(`SPC_SEL_CFG2, 8'hc0);
        hard_wdog = 1'b1;
        // each pin source in turn; the timer must not wake halt
        for (int s = 0; s < 4; s++) begin
            idle();
            chk(mode, SPC_HALT);
            chk({osc, tma_en, cpu_en, wd_en, sclk, nmi}, 6'h01);
            tick_timer();
            chk(mode, SPC_HALT);
            PINS.wake(s);
            wait_run();
        end
        hard_wdog = 1'b0;
        PINS.hv(1'b1);
        repeat (3) step();
        chk(ovr, 1'b1);
        PINS.hv(1'b0);
        // internal_sys_clock pulses over 40 cycles on both variants
        repeat (40) begin
            step();
            n += sclk;
            k += sclk2;
        end
        chk(n, 16'h000a);
        chk(k, 16'h0028);
        for (int s = 0; s < 7; s++) begin
            if (s != 2) wr(3'(s), 8'hff);
            if (s != 2) chk(regs[s], full[s]);
        end
        wr(`SPC_SEL_CFG2, 8'hdb);
        chk({regs[2], priv}, {8'hdb, 1'b0});
        for (int s = 0; s < 7; s++) begin
            wr(3'(s), 8'h00);
            chk(regs[s], prot[s]);
        end
        chk(priv, 1'b0);
        rst_n = 1'b0;
        repeat (3) step();
        rst_n = 1'b1;
        chk({priv, regs[0]}, 9'h100);
        close_out();
    end
endmodule : testbench
